// [design/dbcu_pkg.sv]
// package: command codes, field positions, reset values and carrier types for the command unit
package dbcu_pkg;

   // ==========================================================
   // command encodings
   localparam logic [7:0] CMD_RD_PTR = 8'hA4;
   localparam logic [7:0] CMD_WR_PTR = 8'hA2;
   localparam logic [7:0] CMD_INC_CUR = 8'hA9;
   localparam logic [7:0] CMD_RD_CUR = 8'hAC;
   localparam logic [7:0] CMD_WR_CUR = 8'hAA;
   localparam logic [7:0] CMD_RD_CUR_INC = 8'hAD;
   localparam logic [7:0] CMD_WR_CUR_INC = 8'hAB;
   localparam logic [7:0] CMD_FILL = 8'hBB;
   localparam logic [2:0] GRP_MISC = 3'h1;
   localparam logic [2:0] GRP_RST_STAT = 3'h2;
   localparam logic [2:0] GRP_INT_EN = 3'h3;
   localparam logic [2:0] GRP_INT_DIS = 3'h4;

   // ==========================================================
   // field positions
   localparam int B_ONOFF = 0;
   localparam int B_FLOAT = 2;
   localparam int B_DISP = 3;
   localparam int B_CURS = 4;
   localparam int EV_LPEN = 0;
   localparam int EV_READY = 1;
   localparam int EV_SPLIT = 2;
   localparam int EV_LINE0 = 3;
   localparam int EV_VBLANK = 4;

   // ==========================================================
   // reset values and counts
   localparam logic [4:0] RST_FLAGS = 5'h00;
   localparam logic [4:0] RST_MASK = 5'h00;
   localparam logic [13:0] RST_ADDR = 14'h0000;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic RST_DISP_OFF = 1'b1;
   localparam logic RST_IDLE = 1'b1;
   localparam logic [1:0] INC_TICKS = 2'h3;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      S_IDLE, S_HOLD, S_ACCESS, S_CAPTURE, S_INC, S_FILL, S_FILL_END
   } dbcu_fsm_e;

   typedef struct packed {
      logic hblank;
      logic vblank;
      logic line_start;
      logic field_start;
      logic char_clock;
   } dbcu_raster_s;

   typedef struct packed {
      dbcu_fsm_e fsm;
      logic [7:0] cmd;
      logic [13:0] cursor;
      logic [13:0] pointer;
      logic [7:0] latch;
      logic [4:0] stat;
      logic [4:0] irq;
      logic [4:0] mask;
      logic idle;
      logic disp_off;
      logic on_field;
      logic on_line;
      logic dab_oe;
      logic cursor_en;
      logic fill_blank;
      logic [1:0] inc_cnt;
      logic blank;
      logic cursor_out;
      logic irq_out;
      logic [13:0] dab;
      logic buf_rd;
      logic buf_wr;
      logic [13:0] buf_addr;
   } dbcu_state_s;

endpackage

// [design/dbcu_top.sv]
// command execution unit of a raster display controller
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// RULE1 - A4 reads buffer at pointer into latch; A2 writes latch at pointer.
// RULE2 - AC reads buffer at cursor into latch; AA writes latch at cursor.
// RULE3 - AD reads at cursor then steps; AB writes at cursor then steps.
// RULE4 - A9 only steps cursor; BB fills latch from cursor to pointer.
// RULE5 - display off with bit 2 set floats the display address bus.
// RULE6 - display on resumes blanking at next field or line; drivers re-enabled.
// RULE7 - cursor off holds cursor output low; cursor on restores it.
// RULE8 - reset status clears selected flags: lpen, ready, split, line0, vblank.
// RULE9 - disable interrupts clears selected mask bits, blocking the irq line.
// RULE10 - enable interrupts clears selected flags and sets their mask bits.
// RULE11 - buffer accesses during active screen wait for horizontal blanking.
// RULE12 - buffer accesses in vertical retrace or display off run at once.
// RULE13 - cursor increment starts at once, takes about three char clocks.
// RULE14 - fill starts at once, blanks until vertical blanking after last write.
// RULE15 - host issues no new fill until that blanking release.
// RULE16 - finishing a deferred command sets ready flag and command idle flag.
// RULE17 - host waits for ready or idle before issuing another command.
// RULE18 - pointer transfers move one word using the pointer address.
// RULE19 - cursor increment adds one modulo 16K.
// RULE20 - cursor transfer with increment transfers first, then adds one.
// RULE21 - fill writes every address from cursor to pointer inclusive.
// RULE22 - after fill pointer unchanged and cursor equals pointer.
// RULE23 - host issues commands by writing the command byte.
// RULE24 - immediate commands act at once, never set ready, leave idle untouched.
// RULE25 - display off asserts blanking until display on.
// RULE26 - undefined command bytes are ignored.
module dbcu_top
   import dbcu_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // command write from host logic
   input wire logic i_cmd_wr,
   input wire logic [7:0] i_cmd_data,
   // host writes of latch, cursor and pointer
   input wire logic i_latch_wr,
   input wire logic [7:0] i_latch_data,
   input wire logic i_cursor_wr,
   input wire logic [13:0] i_cursor_data,
   input wire logic i_pointer_wr,
   input wire logic [13:0] i_pointer_data,
   // raster timing and events
   input wire dbcu_raster_s i_raster,
   input wire logic [4:0] i_events,
   input wire logic i_cursor_match,
   input wire logic [13:0] i_refresh_addr,
   // display buffer port
   output logic o_buf_rd,
   output logic o_buf_wr,
   output logic [13:0] o_buf_addr,
   output logic [7:0] o_buf_wdata,
   input wire logic [7:0] i_buf_rdata,
   // display outputs
   output logic o_blank,
   output logic o_cursor,
   output logic [13:0] o_display_address_bus,
   output logic o_display_address_bus_oe,
   // status outputs
   output logic o_command_idle_flag,
   output logic [4:0] o_status,
   output logic [4:0] o_irq_flags,
   output logic [4:0] o_irq_mask,
   output logic o_host_irq_line,
   output logic [13:0] o_cursor_addr,
   output logic [13:0] o_pointer_addr
);

   dbcu_state_s st_q;
   dbcu_state_s st_d;
   logic go;
   logic is_delayed;
   logic [4:0] ev_set;

   // ==========================================================
   // decode helpers
   assign go = i_raster.hblank | i_raster.vblank | st_q.disp_off;
   // RULE4 delayed byte set
   assign is_delayed = (i_cmd_data == CMD_RD_PTR) || (i_cmd_data == CMD_WR_PTR) ||
                       (i_cmd_data == CMD_INC_CUR) || (i_cmd_data == CMD_RD_CUR) ||
                       (i_cmd_data == CMD_WR_CUR) || (i_cmd_data == CMD_RD_CUR_INC) ||
                       (i_cmd_data == CMD_WR_CUR_INC) || (i_cmd_data == CMD_FILL);

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      ev_set = i_events;
      st_d.buf_rd = 1'b0;
      st_d.buf_wr = 1'b0;
      if (i_latch_wr) begin
         st_d.latch = i_latch_data;
      end
      if (i_cursor_wr) begin
         st_d.cursor = i_cursor_data;
      end
      if (i_pointer_wr) begin
         st_d.pointer = i_pointer_data;
      end
      // RULE23 command byte taken
      if (i_cmd_wr) begin
         // RULE24 immediate group, idle untouched
         unique case (i_cmd_data[7:5])
            GRP_MISC: begin
               if (i_cmd_data[B_DISP]) begin
                  if (i_cmd_data[B_ONOFF]) begin
                     // RULE6 resume at field or line
                     st_d.dab_oe = 1'b1;
                     st_d.on_field = i_cmd_data[B_FLOAT];
                     st_d.on_line = ~i_cmd_data[B_FLOAT];
                  end else begin
                     // RULE25 blank until display on
                     st_d.disp_off = 1'b1;
                     st_d.on_field = 1'b0;
                     st_d.on_line = 1'b0;
                     // RULE5 float address bus
                     st_d.dab_oe = ~i_cmd_data[B_FLOAT];
                  end
               end
               if (i_cmd_data[B_CURS]) begin
                  // RULE7 cursor enable
                  st_d.cursor_en = i_cmd_data[B_ONOFF];
               end
            end
            GRP_RST_STAT: begin
               // RULE8 clear selected flags
               st_d.stat = st_q.stat & ~i_cmd_data[4:0];
               st_d.irq = st_q.irq & ~i_cmd_data[4:0];
            end
            GRP_INT_DIS: begin
               // RULE9 clear selected masks
               st_d.mask = st_q.mask & ~i_cmd_data[4:0];
            end
            GRP_INT_EN: begin
               // RULE10 clear flags, set masks
               st_d.stat = st_q.stat & ~i_cmd_data[4:0];
               st_d.irq = st_q.irq & ~i_cmd_data[4:0];
               st_d.mask = st_q.mask | i_cmd_data[4:0];
            end
            default: begin
               // RULE26 delayed or undefined byte
               if (is_delayed && st_q.fsm == S_IDLE) begin
                  st_d.cmd = i_cmd_data;
                  st_d.idle = 1'b0;
                  if (i_cmd_data == CMD_INC_CUR) begin
                     // RULE13 starts regardless of blanking
                     st_d.fsm = S_INC;
                     st_d.inc_cnt = 2'h0;
                  end else if (i_cmd_data == CMD_FILL) begin
                     // RULE14 fill starts at once
                     st_d.fsm = S_FILL;
                     st_d.fill_blank = 1'b1;
                  end else if (go) begin
                     // RULE12 retrace or display off
                     st_d.fsm = S_ACCESS;
                  end else begin
                     // RULE11 wait for horizontal blanking
                     st_d.fsm = S_HOLD;
                  end
               end
            end
         endcase
      end
      // pending display on releases forced blanking, unless a display command in the same cycle cancelled it
      if (st_q.on_field && st_d.on_field && i_raster.field_start) begin
         st_d.disp_off = 1'b0;
         st_d.on_field = 1'b0;
      end
      if (st_q.on_line && st_d.on_line && i_raster.line_start) begin
         st_d.disp_off = 1'b0;
         st_d.on_line = 1'b0;
      end
      ev_set[EV_READY] = 1'b0;
      unique case (st_q.fsm)
         S_IDLE: begin
         end
         S_HOLD: begin
            if (go) begin
               st_d.fsm = S_ACCESS;
            end
         end
         S_ACCESS: begin
            // RULE1 pointer or cursor address select
            // RULE18 one word at pointer
            // RULE2 cursor address access
            if (st_q.cmd == CMD_RD_PTR || st_q.cmd == CMD_WR_PTR) begin
               st_d.buf_addr = st_q.pointer;
            end else begin
               st_d.buf_addr = st_q.cursor;
            end
            st_d.buf_rd = (st_q.cmd == CMD_RD_PTR) || (st_q.cmd == CMD_RD_CUR) ||
                          (st_q.cmd == CMD_RD_CUR_INC);
            st_d.buf_wr = ~st_d.buf_rd;
            st_d.fsm = S_CAPTURE;
         end
         S_CAPTURE: begin
            if (st_q.buf_rd) begin
               st_d.latch = i_buf_rdata;
            end
            // RULE3 step after transfer
            // RULE20 increment follows transfer
            if (st_q.cmd == CMD_RD_CUR_INC || st_q.cmd == CMD_WR_CUR_INC) begin
               st_d.cursor = st_q.cursor + 14'h0001;
            end
            st_d.fsm = S_IDLE;
            ev_set[EV_READY] = 1'b1;
         end
         S_INC: begin
            if (i_raster.char_clock) begin
               st_d.inc_cnt = st_q.inc_cnt + 2'h1;
               if (st_q.inc_cnt == 2'(INC_TICKS - 2'h1)) begin
                  // RULE19 add one, wraps at 16K
                  st_d.cursor = st_q.cursor + 14'h0001;
                  st_d.fsm = S_IDLE;
                  ev_set[EV_READY] = 1'b1;
               end
            end
         end
         S_FILL: begin
            // RULE21 inclusive write sweep
            st_d.buf_wr = 1'b1;
            st_d.buf_addr = st_q.cursor;
            // RULE22 cursor stops at pointer
            if (st_q.cursor == st_q.pointer) begin
               st_d.fsm = S_FILL_END;
            end else begin
               st_d.cursor = st_q.cursor + 14'h0001;
            end
         end
         S_FILL_END: begin
            // RULE14 release at vertical blanking
            if (i_events[EV_VBLANK]) begin
               st_d.fill_blank = 1'b0;
               st_d.fsm = S_IDLE;
               ev_set[EV_READY] = 1'b1;
            end
         end
      endcase
      // RULE16 ready and idle on completion
      if (ev_set[EV_READY]) begin
         st_d.idle = 1'b1;
      end
      // hardware sets win over command clears
      st_d.stat = st_d.stat | ev_set;
      st_d.irq = st_d.irq | (ev_set & st_d.mask);
      st_d.irq_out = |(st_d.irq & st_d.mask);
      st_d.blank = i_raster.hblank | i_raster.vblank | st_d.disp_off | st_d.fill_blank;
      st_d.cursor_out = st_d.cursor_en & i_cursor_match;
      st_d.dab = i_refresh_addr;
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         st_q <= '0;
         st_q.fsm <= S_IDLE;
         st_q.cursor <= RST_ADDR;
         st_q.pointer <= RST_ADDR;
         st_q.buf_addr <= RST_ADDR;
         st_q.latch <= RST_LATCH;
         st_q.stat <= RST_FLAGS;
         st_q.irq <= RST_FLAGS;
         st_q.mask <= RST_MASK;
         st_q.idle <= RST_IDLE;
         st_q.disp_off <= RST_DISP_OFF;
         st_q.blank <= RST_DISP_OFF;
         st_q.dab_oe <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // outputs
   assign o_buf_rd = st_q.buf_rd;
   assign o_buf_wr = st_q.buf_wr;
   assign o_buf_addr = st_q.buf_addr;
   assign o_buf_wdata = st_q.latch;
   assign o_blank = st_q.blank;
   assign o_cursor = st_q.cursor_out;
   assign o_display_address_bus = st_q.dab;
   assign o_display_address_bus_oe = st_q.dab_oe;
   assign o_command_idle_flag = st_q.idle;
   assign o_status = st_q.stat;
   assign o_irq_flags = st_q.irq;
   assign o_irq_mask = st_q.mask;
   assign o_host_irq_line = st_q.irq_out;
   assign o_cursor_addr = st_q.cursor;
   assign o_pointer_addr = st_q.pointer;

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   a_float_on_off: assert property ( // RULE5
      i_cmd_wr && i_cmd_data[7:5] == GRP_MISC && i_cmd_data[B_DISP] && !i_cmd_data[B_ONOFF] &&
      i_cmd_data[B_FLOAT] |=> !o_display_address_bus_oe && o_blank)
      else $error("address bus not floated on display off");

   a_cursor_off_low: assert property ( // RULE7
      !st_q.cursor_en |-> !o_cursor)
      else $error("cursor output high while cursor disabled");

   a_mask_disable: assert property ( // RULE9
      i_cmd_wr && i_cmd_data[7:5] == GRP_INT_DIS |=> (o_irq_mask & $past(i_cmd_data[4:0])) == 5'h00)
      else $error("mask bit survived disable");

   a_enable_sets: assert property ( // RULE10
      i_cmd_wr && i_cmd_data[7:5] == GRP_INT_EN |=> (o_irq_mask & $past(i_cmd_data[4:0])) == $past(i_cmd_data[4:0]))
      else $error("mask bit not set by enable");

   a_hold_active: assert property ( // RULE11
      st_q.fsm == S_HOLD && !go |=> st_q.fsm == S_HOLD && !o_buf_rd && !o_buf_wr)
      else $error("access left hold during active screen");

   a_access_at_once: assert property ( // RULE12
      i_cmd_wr && st_q.fsm == S_IDLE && go && (i_cmd_data == CMD_RD_PTR || i_cmd_data == CMD_WR_CUR)
      |=> st_q.fsm == S_ACCESS ##1 (o_buf_rd || o_buf_wr))
      else $error("access not started at once");

   a_inc_wrap: assert property ( // RULE19
      st_q.fsm == S_INC && i_raster.char_clock && st_q.inc_cnt == 2'h2 && !i_cursor_wr
      |=> o_cursor_addr == 14'($past(st_q.cursor) + 14'h0001) && o_command_idle_flag)
      else $error("cursor increment wrong");

   a_fill_blanked: assert property ( // RULE14
      st_q.fsm == S_FILL || st_q.fsm == S_FILL_END |-> o_blank)
      else $error("blanking dropped during fill");

   a_fill_end_eq: assert property ( // RULE22
      st_q.fsm == S_FILL_END && !i_cursor_wr && !i_pointer_wr |-> st_q.cursor == st_q.pointer)
      else $error("cursor differs from pointer after fill");

   a_ready_done: assert property ( // RULE16
      st_q.fsm != S_IDLE ##1 st_q.fsm == S_IDLE |-> o_command_idle_flag && o_status[EV_READY])
      else $error("ready not flagged on completion");

   a_immed_idle: assert property ( // RULE24
      i_cmd_wr && st_q.fsm == S_IDLE && !is_delayed && st_q.idle |=> o_command_idle_flag)
      else $error("immediate command changed idle flag");

   c_fill_done: cover property (st_q.fsm == S_FILL_END ##1 st_q.fsm == S_IDLE);
   c_inc_done: cover property (st_q.fsm == S_INC ##1 st_q.fsm == S_IDLE);
   c_held_read: cover property (st_q.fsm == S_HOLD ##1 st_q.fsm == S_ACCESS);
   c_display_on: cover property ($fell(st_q.disp_off));

endmodule

// [dv/dbcu_buf_model.sv]
// display buffer memory model on the far side of the buffer port
`timescale 1ns/1ps
module dbcu_buf_model (
   // clock
   input wire logic i_core_clk,
   // buffer port from the unit
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [13:0] i_addr,
   input wire logic [7:0] i_wdata,
   // read data to the unit
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:16383];
   logic [7:0] last_q = 8'h00;
   // data valid only with the strobe, inverted stale value otherwise
   assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
   always @(posedge i_core_clk) begin
      if (i_wr) begin
         mem[i_addr] <= i_wdata;
      end
      if (i_rd) begin
         last_q <= mem[i_addr];
      end
   end
endmodule

// [dv/display_buffer_command_unit_test.sv]
// self-checking bench for the command unit
`timescale 1ns/1ps
module display_buffer_command_unit_test
   import dbcu_pkg::*;
;
   logic clk, rst_n, cmd_wr, lat_wr, cur_wr, ptr_wr, hb, vb, ls, fs, cc, cmatch;
   logic b_rd, b_wr, blank, curs, oe, idle, irq;
   logic [7:0] cmd_d, lat_d, rdata, wdata;
   logic [13:0] cur_d, ptr_d, b_addr, dab, cur_a, ptr_a, rfa;
   logic [4:0] ev, stat, iflg, imask, m;
   dbcu_raster_s ras;
   int fails, cmp_count, wcount, w0;
   int bits [4] = '{0, 2, 3, 4};
   assign ras = {hb, vb, ls, fs, cc};

   dbcu_top uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_cmd_wr(cmd_wr), .i_cmd_data(cmd_d),
      .i_latch_wr(lat_wr), .i_latch_data(lat_d), .i_cursor_wr(cur_wr), .i_cursor_data(cur_d),
      .i_pointer_wr(ptr_wr), .i_pointer_data(ptr_d), .i_raster(ras), .i_events(ev),
      .i_cursor_match(cmatch), .i_refresh_addr(rfa), .o_buf_rd(b_rd), .o_buf_wr(b_wr),
      .o_buf_addr(b_addr), .o_buf_wdata(wdata), .i_buf_rdata(rdata), .o_blank(blank), .o_cursor(curs),
      .o_display_address_bus(dab), .o_display_address_bus_oe(oe), .o_command_idle_flag(idle),
      .o_status(stat), .o_irq_flags(iflg), .o_irq_mask(imask), .o_host_irq_line(irq),
      .o_cursor_addr(cur_a), .o_pointer_addr(ptr_a));
   dbcu_buf_model u_mem (.i_core_clk(clk), .i_rd(b_rd), .i_wr(b_wr), .i_addr(b_addr),
      .i_wdata(wdata), .o_rdata(rdata));

   // ==========================================================
   // clocks, write counter, watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      cc = 1'b0;
      forever begin
         repeat (3) @(posedge clk);
         cc <= 1'b1;
         @(posedge clk);
         cc <= 1'b0;
      end
   end
   always @(posedge clk) begin
      if (b_wr === 1'b1) begin
         wcount <= wcount + 1;
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      wrap_up;
   end

   // ==========================================================
   // access, check and wrap-up tasks
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string s);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t ns: %s got %h want %h", $time, s, g, e);
      end
   endtask
   task cmd(input logic [7:0] b);
      @(posedge clk);
      cmd_wr <= 1'b1;
      cmd_d <= b;
      @(posedge clk);
      cmd_wr <= 1'b0;
   endtask
   task ldl(input logic [7:0] d);
      @(posedge clk);
      lat_wr <= 1'b1;
      lat_d <= d;
      @(posedge clk);
      lat_wr <= 1'b0;
   endtask
   task ldc(input logic [13:0] a);
      @(posedge clk);
      cur_wr <= 1'b1;
      cur_d <= a;
      @(posedge clk);
      cur_wr <= 1'b0;
   endtask
   task ldp(input logic [13:0] a);
      @(posedge clk);
      ptr_wr <= 1'b1;
      ptr_d <= a;
      @(posedge clk);
      ptr_wr <= 1'b0;
   endtask
   task evp(input logic [4:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   task wi(input int n);
      int k;
      k = 0;
      tick(1);
      while (idle !== 1'b1 && k < n) begin
         tick(1);
         k++;
      end
      chk(idle, 1'b1, "idle after command");
   endtask
   task acc(input logic [7:0] wc, input logic [7:0] rc, input logic [13:0] a, input logic [7:0] d,
      input logic cur, input logic [13:0] ca);
      cmd(8'h42);
      if (cur) ldc(a); else ldp(a);
      ldl(d);
      cmd(wc);
      wi(8);
      chk(u_mem.mem[a], d, "buffer write");
      chk(stat[EV_READY], 1'b1, "ready set");
      if (cur) ldc(a);
      ldl(~d);
      cmd(rc);
      wi(8);
      chk(wdata, d, "latch after read");
      if (cur) chk(cur_a, ca, "cursor after access");
   endtask
   task wrap_up;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================================
   // test sequence
   initial begin
      {rst_n, cmd_wr, lat_wr, cur_wr, ptr_wr, hb, vb, ls, fs, cmatch} = '0;
      {cmd_d, lat_d, cur_d, ptr_d, ev, fails, cmp_count, wcount} = '0;
      rfa = 14'h1ABC;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({idle, blank, oe, curs}, 4'hE, "reset outputs");
      chk({stat, imask, cur_a}, 24'h0, "reset flags");
      $display("test reset done");
      acc(CMD_WR_PTR, CMD_RD_PTR, 14'h0123, 8'hA5, 1'b0, 14'h0000);
      acc(CMD_WR_CUR, CMD_RD_CUR, 14'h0200, 8'h77, 1'b1, 14'h0200);
      acc(CMD_WR_CUR_INC, CMD_RD_CUR_INC, 14'h3FFF, 8'h3C, 1'b1, 14'h0000);
      cmd(8'h42);
      tick(2);
      chk({stat[EV_READY], idle}, 2'b01, "ready cleared, idle kept");
      ldc(14'h3FFF);
      cmd(CMD_INC_CUR);
      tick(1);
      chk(idle, 1'b0, "increment started");
      tick(4);
      chk(cur_a, 14'h3FFF, "cursor before third char clock");
      wi(16);
      chk(cur_a, 14'h0000, "cursor wrapped");
      cmd(8'hA0);
      tick(3);
      chk({idle, cur_a}, 15'h4000, "undefined byte");
      $display("test transfers done");
      cmd(8'h29);
      tick(4);
      chk(blank, 1'b1, "blank held until line start");
      @(posedge clk) ls <= 1'b1;
      @(posedge clk) ls <= 1'b0;
      tick(3);
      chk(blank, 1'b0, "blank released at line start");
      ldp(14'h0040);
      ldl(8'h11);
      w0 = wcount;
      cmd(CMD_WR_PTR);
      tick(6);
      chk({idle, 16'(wcount - w0)}, 17'h0, "held in active screen");
      hb <= 1'b1;
      wi(8);
      chk(u_mem.mem[14'h0040], 8'h11, "write in blanking");
      hb <= 1'b0;
      vb <= 1'b1;
      ldp(14'h0041);
      cmd(CMD_WR_PTR);
      wi(4);
      chk(u_mem.mem[14'h0041], 8'h11, "write in retrace");
      vb <= 1'b0;
      $display("test display timing done");
      ldc(14'h0010);
      ldp(14'h0013);
      ldl(8'hC3);
      w0 = wcount;
      cmd(CMD_FILL);
      tick(10);
      chk({idle, blank, 16'(wcount - w0)}, 18'h10004, "fill busy and blanking");
      for (int a = 16; a < 20; a++) chk(u_mem.mem[a], 8'hC3, "fill data");
      evp(5'h10);
      wi(4);
      chk({cur_a, ptr_a}, {14'h0013, 14'h0013}, "addresses after fill");
      chk(stat[EV_READY], 1'b1, "ready after fill");
      tick(2);
      chk(blank, 1'b0, "blank released");
      $display("test fill done");
      cmd(8'h7F);
      tick(2);
      chk({imask, iflg, stat}, 15'h7C00, "enable all");
      m = 5'h1F;
      foreach (bits[i]) begin
         evp(5'(1 << bits[i]));
         tick(2);
         chk({iflg, stat, irq}, {5'(1 << bits[i]), 5'(1 << bits[i]), 1'b1}, "event flag");
         m = m & ~5'(1 << bits[i]);
         cmd(8'h80 | 8'(1 << bits[i]));
         tick(2);
         chk({imask, irq}, {m, 1'b0}, "mask cleared");
         cmd(8'h40 | 8'(1 << bits[i]));
         tick(2);
         chk({iflg, stat, idle}, 11'h001, "flags cleared");
      end
      $display("test interrupts done");
      cmatch <= 1'b1;
      cmd(8'h31);
      tick(3);
      chk(curs, 1'b1, "cursor on");
      cmd(8'h30);
      tick(3);
      chk(curs, 1'b0, "cursor off");
      cmd(8'h2C);
      tick(3);
      chk({oe, blank}, 2'b01, "display off floated");
      cmd(8'h2D);
      tick(2);
      chk(oe, 1'b1, "drivers back");
      @(posedge clk) ls <= 1'b1;
      @(posedge clk) ls <= 1'b0;
      tick(3);
      chk(blank, 1'b1, "waits for field");
      @(posedge clk) fs <= 1'b1;
      @(posedge clk) fs <= 1'b0;
      tick(3);
      chk(blank, 1'b0, "released at field");
      cmd(8'h28);
      tick(3);
      chk({oe, blank, dab}, {1'b1, 1'b1, 14'h1ABC}, "display off driven");
      $display("test display and cursor done");
      wrap_up;
   end
endmodule
